// ==== logic/usb_config_low_bits.sv ====
`timescale 1ns/1ps
module usb_config_low_bits (
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic [7:0]              addr,
   input  wire logic [31:0]             wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic [31:0]                  rdata,
   input  wire usb_cfg_low_pkg::image_t image,
   input  wire logic                    image_load,
   input  wire logic                    usb_reset,
   input  wire logic                    lite_reset,
   input  wire logic                    sync_loss,
   input  wire logic [7:0]              burst_req,
   output logic [7:0]                   burst_limit,
   output logic                         stall_bulk_out,
   output logic                         remote_wake_adv,
   output logic                         self_powered,
   output logic                         hs_lines_swapped
);
   import usb_cfg_low_pkg::*;

   // image defaults latched at the last load
   logic        img_power_r;
   logic        img_power_nxt;
   logic        img_wake_r;
   logic        img_wake_nxt;
   logic        img_swap_r;
   logic        img_swap_nxt;

   // software-visible configuration bits and the burst cap
   logic        burst_limit_enable_r;
   logic        burst_limit_enable_nxt;
   logic        stall_disable_on_sync_loss_r;
   logic        stall_disable_on_sync_loss_nxt;
   logic        power_method_r;
   logic        power_method_nxt;
   logic        remote_wake_support_r;
   logic        remote_wake_support_nxt;
   logic        line_swap_r;
   logic        line_swap_nxt;
   logic [7:0]  burst_cap_r;
   logic [7:0]  burst_cap_nxt;

   // next values of the registered outputs
   logic [31:0] rdata_nxt;
   logic [7:0]  burst_limit_nxt;
   logic        stall_bulk_out_nxt;
   logic        remote_wake_adv_nxt;
   logic        self_powered_nxt;
   logic        hs_lines_swapped_nxt;

   // decoded strobes
   logic        cfg_wr;
   logic        cap_wr;
   logic        cfg_rd;
   logic        cap_rd;
   logic        restore;

   // address match shared by the write and read paths
   function automatic logic reg_hit(input logic       strobe,
                                    input logic [7:0] a,
                                    input logic [7:0] target);
      return strobe && (a == target);
   endfunction

   // eeprom flag first, then the programmed otp value, then the fixed value
   function automatic logic pick_dflt(input logic has_eeprom,
                                      input logic eeprom_val,
                                      input logic has_otp,
                                      input logic otp_val,
                                      input logic fixed_val);
      logic val;
      val = fixed_val;
      // later tests win, so the eeprom takes priority over the otp
      if (has_otp)
         val = otp_val;
      if (has_eeprom)
         val = eeprom_val;
      return val;
   endfunction

   // strobe decode; any other address is ignored on write and reads as zero
   assign cfg_wr  = reg_hit(wr, addr, cfg_addr);
   assign cap_wr  = reg_hit(wr, addr, burst_cap_addr);
   assign cfg_rd  = reg_hit(rd, addr, cfg_addr);
   assign cap_rd  = reg_hit(rd, addr, burst_cap_addr);
   assign restore = usb_reset | lite_reset; // both reapply the last image

   // default chain, evaluated only when a new image arrives
   always_comb begin
      // hold the last image between loads
      img_power_nxt = img_power_r;
      img_wake_nxt  = img_wake_r;
      img_swap_nxt  = img_swap_r;
      if (image_load) begin
         // power method has no otp copy: eeprom flag or fixed value only
         img_power_nxt = pick_dflt(image.eeprom_present, image.eeprom_power_method_flag,
                                   1'b0, 1'b0, power_dflt);
         img_wake_nxt  = pick_dflt(image.eeprom_present, image.eeprom_wake_flag,
                                   image.otp_programmed, image.otp_wake, wake_dflt);
         img_swap_nxt  = pick_dflt(image.eeprom_present, image.eeprom_line_swap_flag,
                                   image.otp_programmed, image.otp_line_swap, swap_dflt);
      end
   end

   // image holding registers; a power-on reset forgets the image
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         img_power_r <= power_dflt;
         img_wake_r  <= wake_dflt;
         img_swap_r  <= swap_dflt;
      end else begin
         img_power_r <= img_power_nxt;
         img_wake_r  <= img_wake_nxt;
         img_swap_r  <= img_swap_nxt;
      end
   end

   // software writes, then the image reapplied on load or bus reset
   always_comb begin
      burst_limit_enable_nxt         = burst_limit_enable_r;
      stall_disable_on_sync_loss_nxt = stall_disable_on_sync_loss_r;
      power_method_nxt               = power_method_r;
      remote_wake_support_nxt        = remote_wake_support_r;
      line_swap_nxt                  = line_swap_r; // read-only, only the image moves it
      burst_cap_nxt                  = burst_cap_r;
      if (cfg_wr) begin
         burst_limit_enable_nxt         = wdata[burst_pos];
         stall_disable_on_sync_loss_nxt = wdata[stall_pos];
         power_method_nxt               = wdata[power_pos];
         remote_wake_support_nxt        = wdata[wake_pos];
      end
      // the swap bit, bit three and the upper bits have no write path
      if (cap_wr)
         burst_cap_nxt = wdata[7:0];
      // a reset in the same cycle as a write overrides the written power and wake bits
      if (image_load || restore) begin
         power_method_nxt        = img_power_nxt;
         remote_wake_support_nxt = img_wake_nxt;
         line_swap_nxt           = img_swap_nxt;
      end
   end

   // configuration registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         // power and wake start at their fixed defaults until an image loads
         burst_limit_enable_r         <= burst_rst;
         stall_disable_on_sync_loss_r <= stall_rst;
         power_method_r               <= power_dflt;
         remote_wake_support_r        <= wake_dflt;
         line_swap_r                  <= swap_dflt;
         burst_cap_r                  <= burst_cap_rst;
      end else begin
         burst_limit_enable_r         <= burst_limit_enable_nxt;
         stall_disable_on_sync_loss_r <= stall_disable_on_sync_loss_nxt;
         power_method_r               <= power_method_nxt;
         remote_wake_support_r        <= remote_wake_support_nxt;
         line_swap_r                  <= line_swap_nxt;
         burst_cap_r                  <= burst_cap_nxt;
      end
   end

   // read mux; data only in the cycle after the strobe, zero otherwise
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (cfg_rd) begin
         // config word: burst enable, swap, wake, power, stall disable
         rdata_nxt[burst_pos] = burst_limit_enable_r;
         rdata_nxt[swap_pos]  = line_swap_r;
         rdata_nxt[wake_pos]  = remote_wake_support_r;
         rdata_nxt[power_pos] = power_method_r;
         rdata_nxt[stall_pos] = stall_disable_on_sync_loss_r;
      end else if (cap_rd) begin
         rdata_nxt[7:0] = burst_cap_r;
      end
   end

   // read data register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= rdata_nxt;
      end
   end

   // link-side values: burst clamp, sticky stall, advertised bits
   always_comb begin
      // with the limit enabled, a request above the cap is cut down to the cap
      burst_limit_nxt = burst_req;
      if (burst_limit_enable_r && (burst_req > burst_cap_r))
         burst_limit_nxt = burst_cap_r;
      // stall holds until a bus reset; a sync loss in that same cycle still wins
      stall_bulk_out_nxt = stall_bulk_out;
      if (restore)
         stall_bulk_out_nxt = 1'b0;
      if (sync_loss && !stall_disable_on_sync_loss_r)
         stall_bulk_out_nxt = 1'b1;
      // copies lag the bits by one cycle so every output leaves a flip-flop
      remote_wake_adv_nxt  = remote_wake_support_r;
      self_powered_nxt     = power_method_r;
      hs_lines_swapped_nxt = line_swap_r;
   end

   // registered link-side outputs; all low while reset is held
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         burst_limit      <= 8'h00;
         stall_bulk_out   <= 1'b0;
         remote_wake_adv  <= 1'b0;
         self_powered     <= 1'b0;
         hs_lines_swapped <= 1'b0;
      end else begin
         burst_limit      <= burst_limit_nxt;
         stall_bulk_out   <= stall_bulk_out_nxt;
         remote_wake_adv  <= remote_wake_adv_nxt;
         self_powered     <= self_powered_nxt;
         hs_lines_swapped <= hs_lines_swapped_nxt;
      end
   end
endmodule

// ==== logic/usb_cfg_low_pkg.sv ====
package usb_cfg_low_pkg;
   localparam logic [7:0] cfg_addr       = 8'h00;
   localparam logic [7:0] burst_cap_addr = 8'h04;
   localparam int         stall_pos      = 0;
   localparam int         power_pos      = 1;
   localparam int         wake_pos       = 2;
   localparam int         swap_pos       = 4;
   localparam int         burst_pos      = 5;
   localparam logic       burst_rst      = 1'b0;
   localparam logic       stall_rst      = 1'b0;
   localparam logic       power_dflt     = 1'b1;
   localparam logic       wake_dflt      = 1'b1;
   localparam logic       swap_dflt      = 1'b0;
   localparam logic [7:0] burst_cap_rst  = 8'h00;

   // image flags offered by the eeprom and otp loaders
   typedef struct packed {
      logic eeprom_present;
      logic eeprom_power_method_flag;
      logic eeprom_wake_flag;
      logic eeprom_line_swap_flag;
      logic otp_programmed;
      logic otp_wake;
      logic otp_line_swap;
   } image_t;
endpackage

// ==== dv/usb_cfg_low_assertions.sv ====
`timescale 1ns/1ps
module usb_cfg_low_chk import usb_cfg_low_pkg::*; (
   input wire logic                    clk,
   input wire logic                    nrst,
   input wire logic                    wr,
   input wire logic                    rd,
   input wire logic                    image_load,
   input wire logic                    usb_reset,
   input wire logic                    lite_reset,
   input wire logic                    sync_loss,
   input wire logic [7:0]              addr,
   input wire logic [7:0]              burst_req,
   input wire logic [7:0]              burst_limit,
   input wire logic [31:0]             wdata,
   input wire logic [31:0]             rdata,
   input wire usb_cfg_low_pkg::image_t image,
   input wire logic                    stall_bulk_out,
   input wire logic                    remote_wake_adv,
   input wire logic                    self_powered,
   input wire logic                    hs_lines_swapped
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   logic cr_r;
   wire  rst_any = usb_reset | lite_reset;
   // marks the cycle in which a config read answers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) cr_r <= 1'b0;
      else cr_r <= rd && addr == cfg_addr;
   end
   a_rsvd_zero: assert property (cr_r |-> rdata[31:6] == 26'h0 && !rdata[3]) else $error("rsvd");
   a_swap_read: assert property (cr_r |-> rdata[4] == hs_lines_swapped) else $error("swap");
   a_wake_read: assert property (cr_r |-> rdata[2] == remote_wake_adv) else $error("wake");
   a_power_read: assert property (cr_r |-> rdata[1] == self_powered) else $error("pwr");
   a_stall_hold: assert property (stall_bulk_out && !rst_any && !$past(rst_any) |=>
      stall_bulk_out) else $error("stall drop");
   a_stall_cause: assert property ($rose(stall_bulk_out) |-> $past(sync_loss) ||
      $past(sync_loss, 2)) else $error("stall cause");
   a_burst_bound: assert property (burst_limit <= $past(burst_req)) else $error("burst");
   a_power_dflt: assert property (image_load && !image.eeprom_present ##1 !wr |=>
      self_powered) else $error("pwr dflt");
   a_wake_dflt: assert property (image_load && image.eeprom_present ##1 !wr |=>
      remote_wake_adv == $past(image.eeprom_wake_flag, 2)) else $error("wake dflt");
   c_stall: cover property ($rose(stall_bulk_out));
   c_swap: cover property (cr_r && hs_lines_swapped);
   c_load: cover property (image_load && image.eeprom_present);
endmodule
bind usb_config_low_bits usb_cfg_low_chk i_chk (.*);

// ==== dv/cfg_image_src.sv ====
`timescale 1ns/1ps
module cfg_image_src import usb_cfg_low_pkg::*; (
   input  wire logic [1:0]          src,
   output usb_cfg_low_pkg::image_t image);
   // 0 blank parts, 1 eeprom fitted, 2 otp programmed only
   always_comb begin
      image = '0;
      if (src == 2'h1) image = 7'h4e;
      if (src == 2'h2) image = 7'h15;
   end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
   import usb_cfg_low_pkg::*;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, image_load = 0, usb_reset = 0, lite_reset = 0;
   logic sync_loss = 0, stall_bulk_out, remote_wake_adv, self_powered, hs_lines_swapped;
   logic [7:0] addr = 8'h00, burst_req = 8'h30, burst_limit;
   logic [31:0] wdata = 32'h0, rdata, r;
   logic [1:0] src = 2'h0;
   image_t image;
   int bad_count = 0, num_checks = 0;
   logic [31:0] w_tab [3] = '{32'hffffffff, 32'h00000000, 32'h00000026};
   logic [31:0] e_tab [3] = '{32'h00000027, 32'h00000000, 32'h00000026};
   always #12.5 clk = ~clk;
   cfg_image_src i_src (.src(src), .image(image));
   usb_config_low_bits i_dut (.*);
   task automatic chk(input logic [31:0] g, e);
      num_checks++;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         bad_count++;
      end
   endtask
   task automatic wr_t(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_t(input logic [7:0] a);
      @(posedge clk);
      {addr, rd} <= {a, 1'b1};
      @(posedge clk);
      rd <= 1'b0;
      #1 r = rdata;
   endtask
   // k: 0 image load, 1 usb reset, 2 lite reset, 3 sync loss
   task automatic pulse(input int k);
      @(posedge clk);
      {sync_loss, lite_reset, usb_reset, image_load} <= 4'h1 << k;
      @(posedge clk);
      {sync_loss, lite_reset, usb_reset, image_load} <= 4'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic end_sim;
      $display("checks=%0d bad=%0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #100000;
      bad_count++;
      end_sim;
   end
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd_t(cfg_addr); chk(r, 32'h6);
      for (int i = 0; i < 3; i++) begin
         wr_t(cfg_addr, w_tab[i]);
         rd_t(cfg_addr); chk(r, e_tab[i]);
         chk({self_powered, remote_wake_adv}, {w_tab[i][1], w_tab[i][2]});
      end
      @(posedge clk) src <= 2'h1;
      pulse(0); rd_t(cfg_addr); chk(r, 32'h30);
      chk(hs_lines_swapped, 1);
      @(posedge clk) src <= 2'h2;
      pulse(0); wr_t(cfg_addr, 0); pulse(2); rd_t(cfg_addr); chk(r, 32'h12);
      pulse(3); chk(stall_bulk_out, 1);
      pulse(1); chk(stall_bulk_out, 0);
      wr_t(cfg_addr, 1); pulse(3); chk(stall_bulk_out, 0);
      wr_t(burst_cap_addr, 32'h10); wr_t(cfg_addr, 32'h21); pulse(4); chk(burst_limit, 8'h10);
      wr_t(cfg_addr, 32'h1); pulse(4); chk(burst_limit, 8'h30);
      wr_t(cfg_addr, 0); pulse(3); chk(stall_bulk_out, 1);
      @(posedge clk) nrst <= 1'b0;
      #1 chk({stall_bulk_out, self_powered, burst_limit}, 0);
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd_t(cfg_addr); chk(r, 32'h6);
      chk({self_powered, remote_wake_adv, hs_lines_swapped}, 3'h6);
      rd_t(8'h08); chk(r, 0);
      end_sim;
   end
endmodule
